//--- hdl/ttc_defs.svh
// constants for the three timer/counter unit: selectors, modes, dividers, reset values
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH
// time base: standard rate is clock/12, fast rate clock/4 (one machine cycle)
`define TTC_DIV_STD 12
`define TTC_DIV_FAST 4
`define TTC_PRESCALE_LAST 4'hB
`define TTC_MC_PHASE 2'h3
// timer 0/1 mode field values
`define TTC_MODE_13BIT 2'h0
`define TTC_MODE_16BIT 2'h1
`define TTC_MODE_RELOAD 2'h2
`define TTC_MODE_SPLIT 2'h3
// software byte write selector
`define TTC_WR_T0_LOW 3'h0
`define TTC_WR_T0_HIGH 3'h1
`define TTC_WR_T1_LOW 3'h2
`define TTC_WR_T1_HIGH 3'h3
`define TTC_WR_T2_LOW 3'h4
`define TTC_WR_T2_HIGH 3'h5
`define TTC_WR_CAP_LOW 3'h6
`define TTC_WR_CAP_HIGH 3'h7
// timebase_select bit positions
`define TTC_TB_T0 0
`define TTC_TB_T1 1
`define TTC_TB_T2 2
// synchronised pin positions
`define TTC_PIN_INT0 0
`define TTC_PIN_EXTERNAL_INTERRUPT_ONE_PIN 1
`define TTC_PIN_CIN0 2
`define TTC_PIN_CIN1 3
`define TTC_PIN_T2CNT 4
`define TTC_PIN_TRIG 5
`define TTC_NUM_PINS 6
// reset values
`define TTC_BYTE_RST 8'h00
`define TTC_TB_RST 3'h0
`define TTC_MODE0_LOW_BITS 5
`endif

//--- hdl/ttc_pkg.sv
// types for the three timer/counter unit
package ttc_pkg;
  typedef logic [1:0] ttc_tmode_t;
  typedef logic [7:0] ttc_byte_t;
  // timer 2 operating mode, one-hot
  typedef enum logic [3:0] {
    TTC_T2_CAPTURE = 4'h1,
    TTC_T2_RELOAD_UP = 4'h2,
    TTC_T2_UPDOWN = 4'h4,
    TTC_T2_BAUD = 4'h8
  } ttc_t2_mode_t;
endpackage

//--- hdl/ttc_top.sv
// three timer/counters: two four-mode counters and one capture/reload up/down counter
`timescale 1ns/10ps
`include "ttc_defs.svh"

// Notes on behaviour
// - mode 0 counts 13 bits: full high byte plus low five low-byte bits
// - mode 0 high byte steps when low bit four falls; high wrap sets flag
// - outside timer 0 split, timers 0/1 count only when running and gate clear or interrupt pin high
// - 13-bit count 1FFFh wraps to 0000h, setting the overflow flag
// - counter function counts falling edges on count pin, else internal ticks
// - timer time base is clock/12 or clock/4 per timebase_select bit
// - mode 1 is a 16-bit counter; FFFFh to 0000h sets overflow flag
// - mode 2 low byte overflow sets flag, reloads from high byte
// - timer 1 in mode 3 halts and holds its count
// - timer 0 mode 3 splits; high byte uses timer 1 run and flag
// - timer 0 in mode 3: timer 1 free of run and flag, mode 3 stops
// - timer 2 clocked by pin or clock/12 or /4, only while t2_run
// - capture mode counts up 16 bits; FFFFh rollover sets t2_overflow_flag
// - capture mode trigger falling edge copies count, sets t2_external_flag
// - capture_clear_enable clears the timer 2 count after each capture
// - up auto-reload: rollover reloads from capture registers, sets overflow flag
// - up auto-reload: enabled trigger falling edge reloads, sets t2_external_flag
// - up/down: counts up while trigger high; overflow reloads from capture
// - up/down: down count at count equal capture loads FFFFh
// - up/down: each reload sets overflow flag (interrupt), toggles external flag (no interrupt)
// - baud mode: 16-bit auto-reload on FFFFh rollover, no overflow flag
// - baud mode: enabled trigger falling edge sets t2_external_flag, interrupt
// - count pins sampled once per machine cycle; high then low is an edge
// - reset clears timebase_select bits, timers start at clock/12
// - timer 2 flags cleared by software; hardware clears only external flag, by up/down toggle
module ttc_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // timer 0/1 configuration
  input wire ttc_pkg::ttc_tmode_t t0_mode,
  input wire ttc_pkg::ttc_tmode_t t1_mode,
  input wire logic t0_gate_select,
  input wire logic t1_gate_select,
  input wire logic t0_timer_counter_select,
  input wire logic t1_timer_counter_select,
  input wire logic timer0_run,
  input wire logic timer1_run,
  // timebase_select write (bit 0 timer 0, bit 1 timer 1, bit 2 timer 2)
  input wire logic timebase_wr,
  input wire logic [2:0] timebase_wdata,
  // timer 2 configuration
  input wire logic t2_run,
  input wire logic t2_clock_select,
  input wire logic capture_reload_select,
  input wire logic t2_external_enable,
  input wire logic capture_clear_enable,
  input wire logic down_count_enable,
  input wire logic receive_baud_select,
  input wire logic transmit_baud_select,
  // software byte writes
  input wire logic sw_wr,
  input wire logic [2:0] sw_wr_sel,
  input wire ttc_pkg::ttc_byte_t sw_wr_data,
  // software flag clears
  input wire logic timer0_flag_clr,
  input wire logic timer1_flag_clr,
  input wire logic t2_overflow_clr,
  input wire logic t2_external_clr,
  // pins from outside
  input wire logic external_interrupt_zero_pin,
  input wire logic external_interrupt_one_pin,
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic t2_count_pin,
  input wire logic trigger_pin,
  // counts and captures
  output ttc_pkg::ttc_byte_t timer0_low_byte,
  output ttc_pkg::ttc_byte_t timer0_high_byte,
  output ttc_pkg::ttc_byte_t timer1_low_byte,
  output ttc_pkg::ttc_byte_t timer1_high_byte,
  output ttc_pkg::ttc_byte_t t2_low_byte,
  output ttc_pkg::ttc_byte_t t2_high_byte,
  output ttc_pkg::ttc_byte_t capture_low_reg,
  output ttc_pkg::ttc_byte_t capture_high_reg,
  // flags and requests
  output logic [2:0] timebase_select,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic t2_overflow_flag,
  output logic t2_external_flag,
  output logic t2_irq
);
  import ttc_pkg::*;

  logic [3:0] prescale_reg;
  logic tick_std;
  logic tick_fast;
  logic [2:0] tb_reg;
  logic [`TTC_NUM_PINS-1:0] pin_raw;
  logic [`TTC_NUM_PINS-1:0] pin_lvl;
  logic [`TTC_NUM_PINS-1:0] pin_fall;
  ttc_byte_t t0_low_reg, t0_high_reg, t1_low_reg, t1_high_reg;
  ttc_byte_t t2_low_reg, t2_high_reg, cap_low_reg, cap_high_reg;
  logic t0_flag_reg, t1_flag_reg, t2_ovf_reg, t2_ext_reg, t2_irq_reg;
  logic t0_split, t1_frozen;
  logic t0_tick, t1_tick, t2_tick, th0_tick;
  logic t0_en, t1_en, th0_en, t2_en;
  logic [16:0] t0_step, t1_step;
  logic t0_ovf_evt, t1_ovf_evt;
  ttc_t2_mode_t t2_mode;
  logic [15:0] t2_cnt, t2_cap, t2_cnt_next, t2_cap_next;
  logic t2_ovf_set, t2_ext_set, t2_ext_tog;
  logic trig_edge;

  // one counter step for timers 0/1 in modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] step_count(input ttc_tmode_t mode, input ttc_byte_t hi,
      input ttc_byte_t lo);
    logic [5:0] low5;
    logic [8:0] high9;
    logic [16:0] full;
    low5 = {1'b0, lo[`TTC_MODE0_LOW_BITS-1:0]} + 6'h01;
    high9 = {1'b0, hi} + {8'h00, low5[5]};
    full = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      `TTC_MODE_13BIT: step_count = {high9[8], high9[7:0], lo[7:5], low5[4:0]};
      `TTC_MODE_16BIT: step_count = full;
      `TTC_MODE_RELOAD: begin
        if (lo == 8'hFF) begin
          step_count = {1'b1, hi, hi};
        end else begin
          step_count = {1'b0, hi, lo + 8'h01};
        end
      end
      default: step_count = {1'b0, hi, lo};
    endcase
  endfunction

  // prescaler: clock/12 tick and clock/4 tick (the machine cycle)
  always_ff @(posedge clk) begin
    if (sys_rst || prescale_reg == `TTC_PRESCALE_LAST) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end
  assign tick_std = (prescale_reg == `TTC_PRESCALE_LAST);
  assign tick_fast = (prescale_reg[1:0] == `TTC_MC_PHASE);

  // time base selects; reset puts every timer on the slow rate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tb_reg <= `TTC_TB_RST;
    end else if (timebase_wr) begin
      tb_reg <= timebase_wdata;
    end
  end

  // pins: three-stage sync, agreement filter, one sample per machine cycle
  assign pin_raw = {trigger_pin, t2_count_pin, count_input_one, count_input_zero,
                    external_interrupt_one_pin, external_interrupt_zero_pin};
  generate
    for (genvar i = 0; i < `TTC_NUM_PINS; i++) begin : g_pin
      logic s1_reg, s2_reg, s3_reg, lvl_reg, samp_reg;
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      // sampling once per machine cycle caps counting at clock/8
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          samp_reg <= 1'b0;
        end else if (tick_fast) begin
          samp_reg <= lvl_reg;
        end
      end
      assign pin_lvl[i] = lvl_reg;
      assign pin_fall[i] = tick_fast & samp_reg & ~lvl_reg;
    end
  endgenerate

  // timers 0/1 count enables
  assign t0_split = (t0_mode == `TTC_MODE_SPLIT);
  assign t1_frozen = (t1_mode == `TTC_MODE_SPLIT);
  assign t0_tick = t0_timer_counter_select ? pin_fall[`TTC_PIN_CIN0] :
                   (tb_reg[`TTC_TB_T0] ? tick_fast : tick_std);
  assign t1_tick = t1_timer_counter_select ? pin_fall[`TTC_PIN_CIN1] :
                   (tb_reg[`TTC_TB_T1] ? tick_fast : tick_std);
  // split high byte only counts prescaled clock ticks
  assign th0_tick = tb_reg[`TTC_TB_T0] ? tick_fast : tick_std;
  assign t0_en = timer0_run & (~t0_gate_select | pin_lvl[`TTC_PIN_INT0]) & t0_tick;
  // with timer 0 split, timer 1 loses its run bit and runs unless frozen
  assign t1_en = (t0_split | timer1_run) & ~t1_frozen &
                 (~t1_gate_select | pin_lvl[`TTC_PIN_EXTERNAL_INTERRUPT_ONE_PIN]) & t1_tick;
  assign th0_en = t0_split & timer1_run & th0_tick;
  assign t0_step = step_count(t0_mode, t0_high_reg, t0_low_reg);
  assign t1_step = step_count(t1_mode, t1_high_reg, t1_low_reg);
  assign t0_ovf_evt = t0_en & (t0_split ? (t0_low_reg == 8'hFF) : t0_step[16]);
  // timer 1 flag belongs to the split high byte while timer 0 is split
  assign t1_ovf_evt = t0_split ? (th0_en & (t0_high_reg == 8'hFF)) :
                      (t1_en & t1_step[16]);

  // timer 0 count bytes; a software write in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t0_low_reg <= `TTC_BYTE_RST;
      t0_high_reg <= `TTC_BYTE_RST;
    end else begin
      if (t0_split) begin
        if (t0_en) begin
          t0_low_reg <= t0_low_reg + 8'h01;
        end
        if (th0_en) begin
          t0_high_reg <= t0_high_reg + 8'h01;
        end
      end else if (t0_en) begin
        t0_high_reg <= t0_step[15:8];
        t0_low_reg <= t0_step[7:0];
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_T0_LOW) begin
        t0_low_reg <= sw_wr_data;
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_T0_HIGH) begin
        t0_high_reg <= sw_wr_data;
      end
    end
  end

  // timer 1 count bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_low_reg <= `TTC_BYTE_RST;
      t1_high_reg <= `TTC_BYTE_RST;
    end else begin
      if (t1_en) begin
        t1_high_reg <= t1_step[15:8];
        t1_low_reg <= t1_step[7:0];
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_T1_LOW) begin
        t1_low_reg <= sw_wr_data;
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_T1_HIGH) begin
        t1_high_reg <= sw_wr_data;
      end
    end
  end

  // timer 0/1 flags: an overflow in the clearing cycle still sets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t0_flag_reg <= 1'b0;
      t1_flag_reg <= 1'b0;
    end else begin
      t0_flag_reg <= t0_ovf_evt | (t0_flag_reg & ~timer0_flag_clr);
      t1_flag_reg <= t1_ovf_evt | (t1_flag_reg & ~timer1_flag_clr);
    end
  end

  // timer 2 mode decode; baud selects take precedence
  always_comb begin
    if (receive_baud_select || transmit_baud_select) begin
      t2_mode = TTC_T2_BAUD;
    end else if (capture_reload_select) begin
      t2_mode = TTC_T2_CAPTURE;
    end else if (down_count_enable) begin
      t2_mode = TTC_T2_UPDOWN;
    end else begin
      t2_mode = TTC_T2_RELOAD_UP;
    end
  end

  assign t2_tick = t2_clock_select ? pin_fall[`TTC_PIN_T2CNT] :
                   (tb_reg[`TTC_TB_T2] ? tick_fast : tick_std);
  assign t2_en = t2_run & t2_tick;
  assign trig_edge = t2_external_enable & pin_fall[`TTC_PIN_TRIG];
  assign t2_cnt = {t2_high_reg, t2_low_reg};
  assign t2_cap = {cap_high_reg, cap_low_reg};

  // timer 2 next count, capture and flag events
  always_comb begin
    t2_cnt_next = t2_cnt;
    t2_cap_next = t2_cap;
    t2_ovf_set = 1'b0;
    t2_ext_set = 1'b0;
    t2_ext_tog = 1'b0;
    case (t2_mode)
      TTC_T2_CAPTURE: begin
        if (t2_en) begin
          t2_cnt_next = t2_cnt + 16'h0001;
          t2_ovf_set = (t2_cnt == 16'hFFFF);
        end
        if (trig_edge) begin
          t2_cap_next = t2_cnt;
          t2_ext_set = 1'b1;
          if (capture_clear_enable) begin
            t2_cnt_next = 16'h0000;
          end
        end
      end
      TTC_T2_RELOAD_UP: begin
        if (t2_en) begin
          if (t2_cnt == 16'hFFFF) begin
            t2_cnt_next = t2_cap;
            t2_ovf_set = 1'b1;
          end else begin
            t2_cnt_next = t2_cnt + 16'h0001;
          end
        end
        if (trig_edge) begin
          t2_cnt_next = t2_cap;
          t2_ext_set = 1'b1;
        end
      end
      TTC_T2_UPDOWN: begin
        // trigger pin is direction here, not an event
        if (t2_en && pin_lvl[`TTC_PIN_TRIG]) begin
          if (t2_cnt == 16'hFFFF) begin
            t2_cnt_next = t2_cap;
            t2_ovf_set = 1'b1;
            t2_ext_tog = 1'b1;
          end else begin
            t2_cnt_next = t2_cnt + 16'h0001;
          end
        end else if (t2_en) begin
          if (t2_cnt == t2_cap) begin
            t2_cnt_next = 16'hFFFF;
            t2_ovf_set = 1'b1;
            t2_ext_tog = 1'b1;
          end else begin
            t2_cnt_next = t2_cnt - 16'h0001;
          end
        end
      end
      TTC_T2_BAUD: begin
        if (t2_en) begin
          t2_cnt_next = (t2_cnt == 16'hFFFF) ? t2_cap : t2_cnt + 16'h0001;
        end
        t2_ext_set = trig_edge;
      end
      default: begin
        t2_cnt_next = t2_cnt;
      end
    endcase
  end

  // timer 2 count and capture registers; software writes win
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t2_low_reg <= `TTC_BYTE_RST;
      t2_high_reg <= `TTC_BYTE_RST;
      cap_low_reg <= `TTC_BYTE_RST;
      cap_high_reg <= `TTC_BYTE_RST;
    end else begin
      t2_high_reg <= t2_cnt_next[15:8];
      t2_low_reg <= t2_cnt_next[7:0];
      cap_high_reg <= t2_cap_next[15:8];
      cap_low_reg <= t2_cap_next[7:0];
      if (sw_wr && sw_wr_sel == `TTC_WR_T2_LOW) begin
        t2_low_reg <= sw_wr_data;
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_T2_HIGH) begin
        t2_high_reg <= sw_wr_data;
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_CAP_LOW) begin
        cap_low_reg <= sw_wr_data;
      end
      if (sw_wr && sw_wr_sel == `TTC_WR_CAP_HIGH) begin
        cap_high_reg <= sw_wr_data;
      end
    end
  end

  // timer 2 flags: software clears, up/down toggle can drop external flag; set or toggle beats a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t2_ovf_reg <= 1'b0;
      t2_ext_reg <= 1'b0;
    end else begin
      t2_ovf_reg <= t2_ovf_set | (t2_ovf_reg & ~t2_overflow_clr);
      if (t2_ext_tog) begin
        t2_ext_reg <= ~t2_ext_reg;
      end else begin
        t2_ext_reg <= t2_ext_set | (t2_ext_reg & ~t2_external_clr);
      end
    end
  end

  // request lags the flags by one cycle so the port stays a flip-flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t2_irq_reg <= 1'b0;
    end else begin
      t2_irq_reg <= t2_ovf_reg | (t2_ext_reg & (t2_mode != TTC_T2_UPDOWN));
    end
  end

  // outputs straight from registers
  assign timer0_low_byte = t0_low_reg;
  assign timer0_high_byte = t0_high_reg;
  assign timer1_low_byte = t1_low_reg;
  assign timer1_high_byte = t1_high_reg;
  assign t2_low_byte = t2_low_reg;
  assign t2_high_byte = t2_high_reg;
  assign capture_low_reg = cap_low_reg;
  assign capture_high_reg = cap_high_reg;
  assign timebase_select = tb_reg;
  assign timer0_overflow_flag = t0_flag_reg;
  assign timer1_overflow_flag = t1_flag_reg;
  assign t2_overflow_flag = t2_ovf_reg;
  assign t2_external_flag = t2_ext_reg;
  assign t2_irq = t2_irq_reg;
endmodule

//--- sim/ttc_chk.sv
// concurrent checks on the ports of the three timer/counter unit
`timescale 1ns/10ps
module ttc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration and software strobes
  input wire ttc_pkg::ttc_tmode_t t1_mode,
  input wire logic t0_gate_select,
  input wire logic external_interrupt_zero_pin,
  input wire logic t2_run,
  input wire logic t2_external_enable,
  input wire logic capture_reload_select,
  input wire logic down_count_enable,
  input wire logic receive_baud_select,
  input wire logic transmit_baud_select,
  input wire logic sw_wr,
  input wire logic [2:0] sw_wr_sel,
  input wire logic t2_overflow_clr,
  // observed counts and flags
  input wire ttc_pkg::ttc_byte_t timer0_low_byte,
  input wire ttc_pkg::ttc_byte_t timer1_low_byte,
  input wire ttc_pkg::ttc_byte_t timer1_high_byte,
  input wire ttc_pkg::ttc_byte_t t2_low_byte,
  input wire ttc_pkg::ttc_byte_t t2_high_byte,
  input wire logic [2:0] timebase_select,
  input wire logic t2_overflow_flag,
  input wire logic t2_external_flag,
  input wire logic t2_irq
);
  import ttc_pkg::*;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // decoded timer 2 mode; baud selects outrank everything else
  wire baud = receive_baud_select | transmit_baud_select;
  wire updown = !baud & !capture_reload_select & down_count_enable;
  wire [15:0] t2_cnt = {t2_high_byte, t2_low_byte};
  wire t1_wr = sw_wr & (sw_wr_sel[2:1] == 2'h1);
  wire irq_src = t2_overflow_flag | (t2_external_flag & !updown);
  // eight cycles covers the pin synchroniser and agreement filter that the gate level passes through
  sequence s_gate_shut;
    (t0_gate_select && !external_interrupt_zero_pin && !sw_wr) [*8];
  endsequence
  // capture mode sitting at the top count, no trigger or write to disturb it
  sequence s_t2_top;
    capture_reload_select && !baud && !t2_external_enable && !sw_wr && t2_cnt == 16'hFFFF;
  endsequence
  a_gate_hold: assert property (s_gate_shut |=> $stable(timer0_low_byte))
    else $error("timer 0 counted while its gate was shut");
  a_t1_freeze: assert property (t1_mode == 2'h3 && !t1_wr |=>
    $stable({timer1_high_byte, timer1_low_byte})) else $error("timer 1 moved in mode 3");
  a_t2_halt: assert property (!t2_run && !t2_external_enable && !(sw_wr && sw_wr_sel[2])
    |=> $stable(t2_cnt)) else $error("timer 2 moved while stopped");
  a_rollover_flag: assert property (s_t2_top ##1 t2_cnt == 16'h0000 |-> t2_overflow_flag)
    else $error("timer 2 rollover without overflow flag");
  a_baud_noflag: assert property (baud && !t2_overflow_flag |=> !t2_overflow_flag)
    else $error("overflow flag set in baud mode");
  a_ovf_sticky: assert property (t2_overflow_flag && !t2_overflow_clr |=> t2_overflow_flag)
    else $error("overflow flag dropped without a clear");
  a_irq_source: assert property (1'h1 |=>
    t2_irq == $past(irq_src))
    else $error("timer 2 request does not follow its flags");
  a_tb_reset: assert property ($fell(sys_rst) |-> timebase_select == 3'h0)
    else $error("time base selects not cleared by reset");
endmodule
bind ttc_top ttc_chk u_chk (.*);

//--- sim/ttc_pin_model.sv
// behavioural model of the pins around the timer unit: count pins and trigger
`timescale 1ns/10ps
module ttc_pin_model (
  // commands from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [3:0] npulse,
  input wire logic trig_idle,
  // pins toward the timer unit
  output logic count_input_zero,
  output logic count_input_one,
  output logic t2_count_pin,
  output logic trigger_pin,
  output logic busy
);
  logic low_ph = 1'h0;
  // selected pin dips low; count pins rest high, the trigger at its idle level
  assign count_input_zero = !(low_ph && sel == 2'h0);
  assign count_input_one = !(low_ph && sel == 2'h1);
  assign t2_count_pin = !(low_ph && sel == 2'h2);
  assign trigger_pin = trig_idle && !(low_ph && sel == 2'h3);
  // each level held two machine cycles so a once-per-cycle sampler sees both
  initial begin
    busy = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy = 1'h1;
        repeat (npulse) begin
          #1 low_ph = 1'h1;
          repeat (8) @(posedge clk);
          #1 low_ph = 1'h0;
          repeat (8) @(posedge clk);
        end
        busy = 1'h0;
      end
    end
  end
endmodule

//--- sim/ttc_top_tb.sv
// self-checking bench for the three timer/counter unit
`timescale 1ns/10ps
`include "ttc_defs.svh"
module ttc_top_tb;
  import ttc_pkg::*;
  // design inputs and bench controls, all valued at time zero except the scratch value v
  logic clk = 1'h0, sys_rst = 1'h1, timebase_wr = 1'h0, sw_wr = 1'h0;
  ttc_tmode_t t0_mode = 2'h1, t1_mode = 2'h1;
  logic t0_gate_select = 1'h0, t1_gate_select = 1'h0, t0_timer_counter_select = 1'h0;
  logic t1_timer_counter_select = 1'h0, timer0_run = 1'h0, timer1_run = 1'h0, t2_run = 1'h0;
  logic t2_clock_select = 1'h0, capture_reload_select = 1'h1, t2_external_enable = 1'h0;
  logic capture_clear_enable = 1'h0, down_count_enable = 1'h0, receive_baud_select = 1'h0;
  logic transmit_baud_select = 1'h0, timer0_flag_clr = 1'h0, timer1_flag_clr = 1'h0;
  logic t2_overflow_clr = 1'h0, t2_external_clr = 1'h0, external_interrupt_zero_pin = 1'h1;
  logic external_interrupt_one_pin = 1'h1, go = 1'h0, trig_idle = 1'h1;
  logic [2:0] timebase_wdata = 3'h0, sw_wr_sel = 3'h0;
  ttc_byte_t sw_wr_data = 8'h00;
  logic [1:0] pin_sel = 2'h0;
  logic [3:0] npulse = 4'h0;
  logic [15:0] v;
  // design outputs and pins from the partner
  wire count_input_zero, count_input_one, t2_count_pin, trigger_pin, busy;
  ttc_byte_t timer0_low_byte, timer0_high_byte, timer1_low_byte, timer1_high_byte;
  ttc_byte_t t2_low_byte, t2_high_byte, capture_low_reg, capture_high_reg;
  logic [2:0] timebase_select;
  logic timer0_overflow_flag, timer1_overflow_flag, t2_overflow_flag, t2_external_flag, t2_irq;
  wire [3:0] flags = {t2_external_flag, t2_overflow_flag, timer1_overflow_flag,
    timer0_overflow_flag};
  wire [15:0] t0c = {timer0_high_byte, timer0_low_byte};
  wire [15:0] t1c = {timer1_high_byte, timer1_low_byte};
  wire [15:0] t2c = {t2_high_byte, t2_low_byte};
  wire [15:0] cap = {capture_high_reg, capture_low_reg};
  int err_count = 0, total_checks = 0;
  ttc_top uut (.*);
  ttc_pin_model pins (.clk(clk), .go(go), .sel(pin_sel), .npulse(npulse),
    .trig_idle(trig_idle), .count_input_zero(count_input_zero),
    .count_input_one(count_input_one), .t2_count_pin(t2_count_pin),
    .trigger_pin(trigger_pin), .busy(busy));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'h0, 1'h1);
    close_out();
  endtask
  // every drive lands one nanosecond after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // low byte then high byte with the strobe held, so it never re-rises in one step
  task automatic wr16(input logic [2:0] sel, input logic [15:0] d);
    sw_wr = 1'h1;
    sw_wr_sel = sel;
    sw_wr_data = d[7:0];
    step(1);
    sw_wr_sel = sel + 3'h1;
    sw_wr_data = d[15:8];
    step(1);
    sw_wr = 1'h0;
    step(1);
  endtask
  task automatic clr();
    {timer0_flag_clr, timer1_flag_clr, t2_overflow_clr, t2_external_clr} = 4'hF;
    step(1);
    {timer0_flag_clr, timer1_flag_clr, t2_overflow_clr, t2_external_clr} = 4'h0;
  endtask
  task automatic wait_flag(input int i);
    int k;
    k = 0;
    while (flags[i] !== 1'h1 && k < 400) begin
      step(1);
      k++;
    end
    if (k == 400) give_up();
    else chk(16'(flags[i]), 16'h0001);
  endtask
  task automatic pulse(input logic [1:0] s, input logic [3:0] n);
    int k;
    pin_sel = s;
    npulse = n;
    go = 1'h1;
    step(1);
    go = 1'h0;
    k = 0;
    while (busy && k < 300) begin
      step(1);
      k++;
    end
    if (k == 300) give_up();
  endtask
  // cycles until the timer 0 low byte next changes
  task automatic t0_change(output int k);
    logic [7:0] b;
    b = timer0_low_byte;
    k = 0;
    while (timer0_low_byte === b && k < 50) begin
      step(1);
      k++;
    end
    if (k == 50) give_up();
  endtask
  task automatic gap(input int n);
    int k;
    t0_change(k);
    t0_change(k);
    chk(16'(k), 16'(n));
  endtask
  task automatic t0_go(input ttc_tmode_t m, input logic [15:0] d);
    timer0_run = 1'h0;
    t0_mode = m;
    clr();
    wr16(`TTC_WR_T0_LOW, d);
    timer0_run = 1'h1;
    wait_flag(0);
  endtask
  task automatic t2_go(input logic [15:0] d, input logic r);
    t2_run = 1'h0;
    clr();
    wr16(`TTC_WR_T2_LOW, d);
    t2_run = r;
  endtask
  initial begin
    step(12);
    sys_rst = 1'h0;
    step(1);
    chk(16'(timebase_select), 16'h0000);
    t0_go(`TTC_MODE_16BIT, 16'hFFFE);
    chk(t0c, 16'h0000);
    gap(12);
    timebase_wdata = 3'h1;
    timebase_wr = 1'h1;
    step(1);
    timebase_wr = 1'h0;
    gap(4);
    t0_go(`TTC_MODE_13BIT, 16'hFFFF);
    chk(t0c, 16'h00E0);
    t0_go(`TTC_MODE_RELOAD, 16'h80FF);
    chk(t0c, 16'h8080);
    // gate shut by the interrupt pin, then reopened
    t0_gate_select = 1'h1;
    external_interrupt_zero_pin = 1'h0;
    step(10);
    v = t0c;
    step(40);
    chk(t0c, v);
    external_interrupt_zero_pin = 1'h1;
    step(20);
    chk(16'(t0c !== v), 16'h0001);
    // counter function on three pin pulses
    timer0_run = 1'h0;
    t0_gate_select = 1'h0;
    t0_mode = `TTC_MODE_16BIT;
    t0_timer_counter_select = 1'h1;
    wr16(`TTC_WR_T0_LOW, 16'h0000);
    timer0_run = 1'h1;
    pulse(2'h0, 4'h3);
    step(8);
    chk(t0c, 16'h0003);
    // timer 1 frozen, then timer 0 split borrowing its run and flag
    timer1_run = 1'h1;
    step(30);
    t1_mode = `TTC_MODE_SPLIT;
    step(2);
    v = t1c;
    step(40);
    chk(t1c, v);
    timer0_run = 1'h0;
    t0_timer_counter_select = 1'h0;
    t0_mode = `TTC_MODE_SPLIT;
    clr();
    wr16(`TTC_WR_T0_LOW, 16'hFF00);
    wait_flag(1);
    chk(t0c, 16'h0000);
    timer1_run = 1'h0;
    t1_mode = `TTC_MODE_16BIT;
    v = t1c;
    step(40);
    chk(16'(t1c !== v), 16'h0001);
    // timer 2 capture mode
    t2_go(16'hFFFF, 1'h1);
    wait_flag(2);
    chk(t2c, 16'h0000);
    step(2);
    chk(16'(t2_irq), 16'h0001);
    capture_clear_enable = 1'h1;
    t2_external_enable = 1'h1;
    t2_go(16'hABCD, 1'h0);
    pulse(2'h3, 4'h1);
    wait_flag(3);
    chk(cap, 16'hABCD);
    chk(t2c, 16'h0000);
    // auto-reload counting up: trigger reload, then rollover reload
    capture_reload_select = 1'h0;
    capture_clear_enable = 1'h0;
    t2_go(16'h0005, 1'h0);
    pulse(2'h3, 4'h1);
    wait_flag(3);
    chk(t2c, 16'hABCD);
    t2_external_enable = 1'h0;
    t2_go(16'hFFFF, 1'h1);
    wait_flag(2);
    chk(t2c, 16'hABCD);
    // up/down: down through the capture value, then up through the top
    down_count_enable = 1'h1;
    trig_idle = 1'h0;
    wr16(`TTC_WR_CAP_LOW, 16'h0010);
    t2_go(16'h0012, 1'h1);
    wait_flag(2);
    chk(t2c, 16'hFFFF);
    chk(16'(t2_external_flag), 16'h0001);
    t2_run = 1'h0;
    t2_overflow_clr = 1'h1;
    step(1);
    t2_overflow_clr = 1'h0;
    step(2);
    chk(16'(t2_irq), 16'h0000);
    clr();
    trig_idle = 1'h1;
    t2_run = 1'h1;
    wait_flag(2);
    chk(t2c, 16'h0010);
    // baud generator: silent reload, trigger still flags
    down_count_enable = 1'h0;
    receive_baud_select = 1'h1;
    t2_go(16'hFFFF, 1'h1);
    step(30);
    chk(16'(t2c - 16'h0010 < 16'h0003), 16'h0001);
    chk(16'(t2_overflow_flag), 16'h0000);
    receive_baud_select = 1'h0;
    transmit_baud_select = 1'h1;
    t2_external_enable = 1'h1;
    pulse(2'h3, 4'h1);
    wait_flag(3);
    // timer 2 clocked from its own pin: two falls, two counts
    t2_clock_select = 1'h1;
    v = t2c;
    pulse(2'h2, 4'h2);
    chk(t2c - v, 16'h0002);
    close_out();
  end
endmodule
